// ===== verilog/pwdt_core.v
// watchdog hardware takeover for a four-port power-sourcing controller
// assumes a byte register port driven by the serial interface logic and
// port state machines that obey the mode, power and reset strobes
//
// Overview of operation
// - clear-all pushbutton clears every event register and matching interrupt bits
// - port soft reset removes power and reinitialises only that port's state
// - global pushbuttons self-clear after acting; command register resets to zero
// - chip soft reset returns every register to its reset value
// - takeover flags work only while the watchdog enable bit is set
// - flag rises when the count hits zero and the port goes hardware-controlled
// - flag also rises on every refused software power-on under hardware control
// - four flags in bits 3..0, cleared on read, upper bits reserved
// - while enabled the count decrements by one every 164 ms to zero
// - at zero the device enters hardware control, each port takes its mode
// - under hardware control every power-on request is ignored
// - under hardware control software cannot change a port's mode
// - on expiry takeover bit low forces mode 00, high forces mode 11
// - with takeover interrupt enabled, any set flag raises the interrupt
// - switch mode register resets to zero: watchdog off, all ports shutdown
// - gate pullup current is 50 uA minus 6.25 uA per code step
// - ac threshold is 213.68 uA plus 28.33 uA per code step
// - detect-skip permit low blocks auto power-on after bypassed detection
// - startup limit is 135 mV plus 19.25 mV per step, fault 88 percent
// - program register one resets to 04h
// - command bits: 7 clear irqs, 4 chip reset, 3..0 port resets; write-only
`timescale 1ns/1ps
`default_nettype none
`include "pwdt_defines.vh"

module pwdt_core #(
   parameter TICK_CYCLES = `PWDT_TICK_CYCLES,
   parameter PRE_W       = 24
)(
   input  wire        core_clk,
   input  wire        reset,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire [3:0]  detect_bypassed,
   output reg  [7:0]  port_mode,
   output reg         hw_control,
   output reg  [3:0]  power_on_req,
   output reg  [3:0]  power_off_req,
   output reg  [3:0]  port_soft_reset,
   output reg         clear_all_events,
   output reg         chip_soft_reset,
   output reg         takeover_irq,
   output reg  [3:0]  power_on_inhibit,
   output reg  [7:0]  gate_and_ac_config,
   output reg  [7:0]  prog2_config,
   output reg  [12:0] gate_pullup_current,
   output reg  [15:0] ac_disconnect_threshold,
   output reg  [15:0] startup_limit_voltage,
   output reg  [15:0] fault_limit_voltage
);

   reg  [3:0] hw_takeover_flag;
   reg  [7:0] watchdog_count;
   reg  [7:0] takeover_mode_select;
   reg  [3:0] next_flags;
   reg  [7:0] next_port_mode;
   integer    i;
   integer    j;

   wire       soft_rst;
   wire       wd_tick;
   wire       watchdog_enable_bit;
   wire       takeover_irq_enable;
   wire [3:0] takeover_port_mode;
   wire       expire;
   wire       wr_mode;
   wire       wr_power;
   wire       wr_cmd;
   wire       wr_count;
   wire       wr_switch;
   wire       wr_prog1;
   wire       wr_prog2;
   wire       rd_flags;
   wire [3:0] refused_on;
   wire [2:0] gate_pullup_code;
   wire [2:0] ac_disconnect_threshold_code;
   wire       detect_skip_permit;
   wire [3:0] current_limit_code;

   // chip soft reset acts one cycle after its write, through the same path as reset
   assign soft_rst = reset | chip_soft_reset;

   // register decodes
   assign wr_mode   = reg_wr && (reg_addr == `PWDT_ADDR_PORT_MODE);
   assign wr_power  = reg_wr && (reg_addr == `PWDT_ADDR_POWER_BTN);
   assign wr_cmd    = reg_wr && (reg_addr == `PWDT_ADDR_GLOBAL_CMD);
   assign wr_count  = reg_wr && (reg_addr == `PWDT_ADDR_WD_COUNT);
   assign wr_switch = reg_wr && (reg_addr == `PWDT_ADDR_SWITCH_MODE);
   assign wr_prog1  = reg_wr && (reg_addr == `PWDT_ADDR_PROG1);
   assign wr_prog2  = reg_wr && (reg_addr == `PWDT_ADDR_PROG2);
   assign rd_flags  = reg_rd && (reg_addr == `PWDT_ADDR_FLAGS);

   // switch mode and config fields
   assign watchdog_enable_bit = takeover_mode_select[`PWDT_SM_WATCHDOG_ENABLE];
   assign takeover_irq_enable = takeover_mode_select[`PWDT_SM_IRQ_ENABLE];
   assign takeover_port_mode  = takeover_mode_select[3:0];
   assign gate_pullup_code             = gate_and_ac_config[7:5];
   assign ac_disconnect_threshold_code = gate_and_ac_config[2:0];
   assign detect_skip_permit = gate_and_ac_config[`PWDT_P1_DETECT_SKIP];
   assign current_limit_code = prog2_config[7:4];

   // expiry: enabled, count at zero, not yet taken over
   assign expire = watchdog_enable_bit && (watchdog_count == 8'h00) && !hw_control;

   // a software power-on under hardware control is refused and recorded
   assign refused_on = (wr_power && hw_control) ? reg_wdata[3:0] : 4'h0;

   // decrement tick; keeps counting whatever software writes to the count
   pwdt_prescale #(
      .TICK_CYCLES (TICK_CYCLES),
      .PRE_W       (PRE_W)
   ) u_prescale (
      .core_clk (core_clk),
      .reset    (soft_rst),
      .run      (watchdog_enable_bit),
      .tick     (wd_tick)
   );

   // global pushbuttons: one-cycle strobes that drop back to zero by themselves
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         clear_all_events <= 1'b0;
         chip_soft_reset  <= 1'b0;
         port_soft_reset  <= 4'h0;
      end
      else
      begin
         clear_all_events <= wr_cmd & reg_wdata[`PWDT_GC_CLEAR_ALL_IRQ];
         chip_soft_reset  <= wr_cmd & reg_wdata[`PWDT_GC_CHIP_SOFT_RESET];
         port_soft_reset  <= wr_cmd ? reg_wdata[3:0] : 4'h0;
      end
   end

   // power pushbuttons; a port soft reset also removes that port's power
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         power_on_req  <= 4'h0;
         power_off_req <= 4'h0;
      end
      else
      begin
         power_on_req  <= (wr_power && !hw_control) ? reg_wdata[3:0] : 4'h0;
         power_off_req <= (wr_power ? reg_wdata[7:4] : 4'h0)
                          | (wr_cmd ? reg_wdata[3:0] : 4'h0);
      end
   end

   // watchdog count: a software write wins over the decrement in the same cycle
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         watchdog_count <= `PWDT_RST_WD_COUNT;
      end
      else if (wr_count)
      begin
         watchdog_count <= reg_wdata;
      end
      else if (watchdog_enable_bit && wd_tick && (watchdog_count != 8'h00))
      begin
         watchdog_count <= watchdog_count - 8'h01;
      end
   end

   // switch mode register; reserved bits are not stored
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         takeover_mode_select <= `PWDT_RST_SWITCH_MODE;
      end
      else if (wr_switch)
      begin
         takeover_mode_select <= reg_wdata & `PWDT_SM_STORE_MASK;
      end
   end

   // hardware control holds until the watchdog is disabled or the chip is reset
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         hw_control <= 1'b0;
      end
      else if (!watchdog_enable_bit)
      begin
         hw_control <= 1'b0;
      end
      else if (expire)
      begin
         hw_control <= 1'b1;
      end
   end

   // next port mode: expiry forces each field, software writes only in software control
   always @*
   begin
      next_port_mode = port_mode;
      if (expire)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            next_port_mode[2*i +: 2] = takeover_port_mode[i] ?
                                       `PWDT_MODE_AUTO : `PWDT_MODE_SHUTDOWN;
         end
      end
      else if (wr_mode && !hw_control)
      begin
         next_port_mode = reg_wdata;
      end
   end

   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         port_mode <= `PWDT_RST_PORT_MODE;
      end
      else
      begin
         port_mode <= next_port_mode;
      end
   end

   // takeover flags: clears first, then sets, so an event in a clearing cycle survives
   always @*
   begin
      next_flags = hw_takeover_flag;
      if (rd_flags || clear_all_events)
      begin
         next_flags = 4'h0;
      end
      next_flags = next_flags & ~port_soft_reset;
      if (watchdog_enable_bit)
      begin
         if (expire)
         begin
            next_flags = 4'hf;
         end
         next_flags = next_flags | refused_on;
      end
   end

   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         hw_takeover_flag <= `PWDT_RST_FLAGS;
      end
      else if (!watchdog_enable_bit)
      begin
         hw_takeover_flag <= next_flags & ~refused_on;
      end
      else
      begin
         hw_takeover_flag <= next_flags;
      end
   end

   // interrupt follows the flags one cycle later
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         takeover_irq <= 1'b0;
      end
      else
      begin
         takeover_irq <= takeover_irq_enable && (hw_takeover_flag != 4'h0);
      end
   end

   // program registers
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         gate_and_ac_config <= `PWDT_RST_PROG1;
         prog2_config       <= `PWDT_RST_PROG2;
      end
      else
      begin
         if (wr_prog1)
         begin
            gate_and_ac_config <= reg_wdata;
         end
         if (wr_prog2)
         begin
            prog2_config <= reg_wdata;
         end
      end
   end

   // analog settings in hundredths of a microamp or millivolt, one cycle behind the code
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         gate_pullup_current     <= `PWDT_IPU_BASE;
         ac_disconnect_threshold <= `PWDT_IAC_BASE;
         startup_limit_voltage   <= `PWDT_VSU_BASE;
         fault_limit_voltage     <= `PWDT_VFLT_BASE;
      end
      else
      begin
         gate_pullup_current <= `PWDT_IPU_BASE
                                - `PWDT_IPU_STEP * {10'h000, gate_pullup_code};
         ac_disconnect_threshold <= `PWDT_IAC_BASE
                                + `PWDT_IAC_STEP * {13'h0000, ac_disconnect_threshold_code};
         startup_limit_voltage <= `PWDT_VSU_BASE
                                - 16'h0000 + `PWDT_VSU_STEP * {12'h000, current_limit_code};
         // fault limit uses pre-scaled constants so no divider is needed
         fault_limit_voltage <= `PWDT_VFLT_BASE
                                + `PWDT_VFLT_STEP * {12'h000, current_limit_code};
      end
   end

   // auto ports with bypassed detection are held off unless the skip is permitted
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         power_on_inhibit <= 4'h0;
      end
      else
      begin
         for (j = 0; j < 4; j = j + 1)
         begin
            power_on_inhibit[j] <= !detect_skip_permit && detect_bypassed[j]
                                   && (port_mode[2*j +: 2] == `PWDT_MODE_AUTO);
         end
      end
   end

   // read data, one cycle after the strobe; pushbuttons and unmapped offsets read zero
   always @(posedge core_clk)
   begin
      if (soft_rst)
      begin
         reg_rdata <= 8'h00;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            `PWDT_ADDR_PORT_MODE:   reg_rdata <= port_mode;
            `PWDT_ADDR_FLAGS:       reg_rdata <= {4'h0, hw_takeover_flag};
            `PWDT_ADDR_WD_COUNT:    reg_rdata <= watchdog_count;
            `PWDT_ADDR_SWITCH_MODE: reg_rdata <= takeover_mode_select;
            `PWDT_ADDR_PROG1:       reg_rdata <= gate_and_ac_config;
            `PWDT_ADDR_PROG2:       reg_rdata <= prog2_config;
            default:                reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule

`default_nettype wire

// ===== verilog/pwdt_defines.vh
// register offsets, field positions, reset values and timing counts
// for the port watchdog takeover block; definitions only
`ifndef PWDT_DEFINES_VH
`define PWDT_DEFINES_VH

// register offsets
`define PWDT_ADDR_PORT_MODE     8'h12
`define PWDT_ADDR_POWER_BTN     8'h19
`define PWDT_ADDR_GLOBAL_CMD    8'h1a
`define PWDT_ADDR_FLAGS         8'h1c
`define PWDT_ADDR_WD_COUNT      8'h1e
`define PWDT_ADDR_SWITCH_MODE   8'h1f
`define PWDT_ADDR_PROG1         8'h23
`define PWDT_ADDR_PROG2         8'h27

// reset values
`define PWDT_RST_PORT_MODE      8'h00
`define PWDT_RST_FLAGS          4'h0
`define PWDT_RST_WD_COUNT       8'h00
`define PWDT_RST_SWITCH_MODE    8'h00
`define PWDT_RST_PROG1          8'h04
`define PWDT_RST_PROG2          8'h47

// field positions
`define PWDT_GC_CLEAR_ALL_IRQ   7
`define PWDT_GC_CHIP_SOFT_RESET 4
`define PWDT_SM_WATCHDOG_ENABLE 7
`define PWDT_SM_IRQ_ENABLE      6
`define PWDT_SM_STORE_MASK      8'hcf
`define PWDT_P1_DETECT_SKIP     4
`define PWDT_P1_OSC_OVERRIDE    3

// port mode encodings
`define PWDT_MODE_SHUTDOWN      2'h0
`define PWDT_MODE_AUTO          2'h3

// analog code scaling, in hundredths of a microamp or millivolt
`define PWDT_IPU_BASE           13'h1388
`define PWDT_IPU_STEP           13'h0271
`define PWDT_IAC_BASE           16'h5378
`define PWDT_IAC_STEP           16'h0b11
`define PWDT_VSU_BASE           16'h34bc
`define PWDT_VSU_STEP           16'h0785
`define PWDT_VFLT_BASE          16'h2e68
`define PWDT_VFLT_STEP          16'h069e

// watchdog decrement period: time in ms, clock in kHz, count derived
`define PWDT_WD_TICK_MS         32'h0000_00a4
`define PWDT_CLK_KHZ            32'h0001_86a0
`define PWDT_TICK_CYCLES        (`PWDT_WD_TICK_MS * `PWDT_CLK_KHZ)

`endif

// ===== verilog/pwdt_prescale.v
// prescaler that counts while run is high and emits a one-cycle tick per period
// assumes a synchronous active-high reset that also covers soft reset
`timescale 1ns/1ps
`default_nettype none

module pwdt_prescale #(
   parameter TICK_CYCLES = 16400000,
   parameter PRE_W       = 24
)(
   input  wire core_clk,
   input  wire reset,
   input  wire run,
   output reg  tick
);

   localparam integer LAST_I = TICK_CYCLES - 1;
   localparam [PRE_W-1:0] LAST = LAST_I[PRE_W-1:0];

   reg [PRE_W-1:0] count;

   // restarts whenever the watchdog is off, so the first tick is a full period away
   always @(posedge core_clk)
   begin
      if (reset || !run)
      begin
         count <= {PRE_W{1'b0}};
         tick  <= 1'b0;
      end
      else if (count == LAST)
      begin
         count <= {PRE_W{1'b0}};
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 1'b1;
         tick  <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ===== verif/pwdt_props.sv
// concurrent checks on the port watchdog takeover block
// sees only pwdt_core ports; bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pwdt_props #(
   parameter TICK_CYCLES = 10
)(
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [3:0]  detect_bypassed,
   input wire logic [7:0]  port_mode,
   input wire logic        hw_control,
   input wire logic [3:0]  power_on_req,
   input wire logic [3:0]  port_soft_reset,
   input wire logic        clear_all_events,
   input wire logic        chip_soft_reset,
   input wire logic [3:0]  power_on_inhibit,
   input wire logic [7:0]  gate_and_ac_config,
   input wire logic [7:0]  prog2_config,
   input wire logic [12:0] gate_pullup_current,
   input wire logic [15:0] ac_disconnect_threshold,
   input wire logic [15:0] startup_limit_voltage,
   input wire logic [15:0] fault_limit_voltage
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // per-port auto and half-set mode fields; takeover never leaves a half-set field
   wire [3:0] auto_vec = {&port_mode[7:6], &port_mode[5:4], &port_mode[3:2], &port_mode[1:0]};
   wire [3:0] odd_vec  = {^port_mode[7:6], ^port_mode[5:4], ^port_mode[3:2], ^port_mode[1:0]};
   wire       cmd_wr   = reg_wr && reg_addr == 8'h1a;

   property p_takeover_mode;
      $rose(hw_control) |-> odd_vec == 4'h0;
   endproperty
   a_takeover_mode: assert property (p_takeover_mode)
      else $error("takeover left a port in a mixed mode");
   property p_no_power_on;
      hw_control && $past(hw_control) |-> power_on_req == 4'h0;
   endproperty
   a_no_power_on: assert property (p_no_power_on)
      else $error("power on passed under hardware control");
   property p_mode_frozen;
      hw_control && $past(hw_control) && port_soft_reset == 4'h0 |-> $stable(port_mode);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("port mode changed under hardware control");
   property p_power_on_pulse;
      reg_wr && reg_addr == 8'h19 && !hw_control |=> power_on_req == $past(reg_wdata[3:0]);
   endproperty
   a_power_on_pulse: assert property (p_power_on_pulse)
      else $error("power on pulse does not match the write");
   property p_port_reset;
      cmd_wr |=> port_soft_reset == $past(reg_wdata[3:0]);
   endproperty
   a_port_reset: assert property (p_port_reset)
      else $error("port soft reset pulse does not match the write");
   property p_clear_cause;
      clear_all_events |-> $past(cmd_wr && reg_wdata[7]);
   endproperty
   a_clear_cause: assert property (p_clear_cause)
      else $error("clear all pulse without its write");
   property p_chip_reset;
      chip_soft_reset |=> !chip_soft_reset && !hw_control && port_mode == 8'h00 &&
         gate_and_ac_config == 8'h04;
   endproperty
   a_chip_reset: assert property (p_chip_reset)
      else $error("chip soft reset left state behind");
   property p_flags_upper;
      reg_rd && reg_addr == 8'h1c |=> reg_rdata[7:4] == 4'h0;
   endproperty
   a_flags_upper: assert property (p_flags_upper)
      else $error("reserved flag bits read non-zero");
   property p_inhibit;
      !$past(reset) && !$past(chip_soft_reset) |-> power_on_inhibit ==
         $past(~{4{gate_and_ac_config[4]}} & detect_bypassed & auto_vec);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("power on inhibit wrong");
   property p_gate_ac;
      !$past(reset) && !$past(chip_soft_reset) |->
         gate_pullup_current == $past(13'h1388 - 13'h0271 * gate_and_ac_config[7:5])
         && ac_disconnect_threshold == $past(16'h5378 + 16'h0b11 * gate_and_ac_config[2:0]);
   endproperty
   a_gate_ac: assert property (p_gate_ac)
      else $error("gate or ac threshold value wrong");
   property p_limits;
      !$past(reset) && !$past(chip_soft_reset) |->
         startup_limit_voltage == $past(16'h34bc + 16'h0785 * prog2_config[7:4])
         && fault_limit_voltage == $past(16'h2e68 + 16'h069e * prog2_config[7:4]);
   endproperty
   a_limits: assert property (p_limits)
      else $error("current limit voltages wrong");
endmodule
`default_nettype wire

// ===== verif/pwdt_host.sv
// host software model: byte register writes and reads
// assumes pwdt_core register port timing; data valid the cycle after a read
`timescale 1ns/1ps
`default_nettype none
module pwdt_host (
   input  wire logic       core_clk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // released lines show the inverse so stale data never looks valid
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
   // keep-alive rewrite of the count with a non-zero value
   task kick(input logic [7:0] v);
      wr(8'h1e, v);
   endtask
endmodule
`default_nettype wire

// ===== verif/port_watchdog_takeover_bench.sv
// self-checking bench for the port watchdog takeover block
// host model drives the register port; prescaler shortened to ten cycles
`timescale 1ns/1ps
`default_nettype none
module port_watchdog_takeover_bench;
   localparam TICK_CYCLES = 10;
   logic        core_clk;
   logic        reset;
   logic [3:0]  detect_bypassed;
   wire  [7:0]  reg_addr, reg_wdata, reg_rdata, port_mode, gate_and_ac_config, prog2_config;
   wire         reg_wr, reg_rd, hw_control, clear_all_events, chip_soft_reset, takeover_irq;
   wire  [3:0]  power_on_req, power_off_req, port_soft_reset, power_on_inhibit;
   wire  [12:0] gate_pullup_current;
   wire  [15:0] ac_disconnect_threshold, startup_limit_voltage, fault_limit_voltage;
   logic [7:0]  rdv;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cyc = 0;

   pwdt_core #(.TICK_CYCLES(TICK_CYCLES), .PRE_W(24)) i_dut (.*);
   pwdt_host i_host (.*);

   // free-running clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // a hang counts as a mismatch and closes the run
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         fail_count++;
         test_done();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rdchk(input logic [7:0] a, input logic [7:0] e);
      i_host.rd(a, rdv);
      chk({8'h00, rdv}, {8'h00, e});
   endtask
   task test_done;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      reset = 1'b1;
      detect_bypassed = 4'hf;
      repeat (12) @(posedge core_clk);
      #1;
      reset = 1'b0;
      // reset values and an unmapped offset
      rdchk(8'h1c, 8'h00);
      rdchk(8'h1f, 8'h00);
      rdchk(8'h23, 8'h04);
      rdchk(8'h40, 8'h00);
      // host keeps rewriting the count, so no takeover happens
      i_host.wr(8'h1e, 8'h02);
      i_host.wr(8'h1f, 8'h80);
      repeat (6)
      begin
         repeat (6) @(posedge core_clk);
         i_host.kick(8'h02);
      end
      chk(hw_control, 16'h0);
      // restart the prescaler and let the count run out; ports 0 and 2 go auto
      i_host.wr(8'h1f, 8'h00);
      i_host.wr(8'h1e, 8'h02);
      i_host.wr(8'h1f, 8'h85);
      repeat (4) @(posedge core_clk);
      rdchk(8'h1e, 8'h02);
      repeat (6) @(posedge core_clk);
      rdchk(8'h1e, 8'h01);
      chk(hw_control, 16'h0);
      for (int i = 0; i < 15 && hw_control !== 1'b1; i++)
      begin
         @(posedge core_clk);
         #1;
      end
      chk(hw_control, 16'h1);
      chk(port_mode, 16'h33);
      rdchk(8'h12, 8'h33);
      rdchk(8'h1c, 8'h0f);
      rdchk(8'h1c, 8'h00);
      chk(power_on_inhibit, 16'h5);
      chk(takeover_irq, 16'h0);
      // mode writes and power-on requests are refused under hardware control
      i_host.wr(8'h12, 8'hff);
      chk(port_mode, 16'h33);
      i_host.wr(8'h19, 8'h01);
      chk(power_on_req, 16'h0);
      rdchk(8'h1c, 8'h01);
      i_host.wr(8'h1f, 8'hf5);
      rdchk(8'h1f, 8'hc5);
      i_host.wr(8'h19, 8'h02);
      @(posedge core_clk);
      #1;
      chk(takeover_irq, 16'h1);
      // pushbuttons: clear all, then a single port reset
      i_host.wr(8'h1a, 8'h80);
      chk(clear_all_events, 16'h1);
      rdchk(8'h1c, 8'h00);
      chk(clear_all_events, 16'h0);
      chk(takeover_irq, 16'h0);
      rdchk(8'h1a, 8'h00);
      i_host.wr(8'h1a, 8'h04);
      chk(port_soft_reset, 16'h4);
      chk(power_off_req, 16'h4);
      // analog codes; detect-skip permit set clears the inhibit
      i_host.wr(8'h23, 8'hb6);
      i_host.wr(8'h27, 8'h37);
      @(posedge core_clk);
      #1;
      chk({3'h0, gate_pullup_current}, 16'h0753);
      chk(ac_disconnect_threshold, 16'h95de);
      chk(startup_limit_voltage, 16'h4b4b);
      chk(fault_limit_voltage, 16'h4242);
      chk(power_on_inhibit, 16'h0);
      // leaving hardware control lets power-on through again
      i_host.wr(8'h1f, 8'h05);
      i_host.wr(8'h19, 8'h08);
      chk(power_on_req, 16'h8);
      rdchk(8'h1c, 8'h00);
      // chip soft reset returns the map to reset values
      i_host.wr(8'h1e, 8'h55);
      i_host.wr(8'h1a, 8'h10);
      chk(chip_soft_reset, 16'h1);
      rdchk(8'h1e, 8'h00);
      rdchk(8'h23, 8'h04);
      rdchk(8'h1f, 8'h00);
      test_done();
   end
endmodule

bind pwdt_core pwdt_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (.*);
`default_nettype wire
